// ---- logic/sfce_map.vh ----
`ifndef SFCE_MAP_VH
`define SFCE_MAP_VH
// How it works
// R1 - quick read: code, three address bytes, one dummy byte, then data
// R2 - input bits sampled on rising serial clock, output shifted on falling
// R3 - read address increments per byte and wraps to zero after the top
// R4 - chip select high ends read anytime; output driver released
// R5 - quick read rejected while a program or erase cycle runs
// R6 - program and erase need the write enable latch set beforehand
// R7 - program frame: code, three address bytes, one or more data bytes
// R8 - program data past page end wraps to page start
// R9 - more than 256 bytes: only last 256 kept in same page
// R10 - fewer bytes: only addressed locations change
// R11 - program executes only if chip select rises on byte boundary
// R12 - program only clears bits; erase sets them back to one
// R13 - cycle starts at chip select rise; busy flag high; latch cleared before end
// R14 - program into protected page is not executed
// R15 - region clear sets whole sector containing address to ones
// R16 - region clear executes only if select rises right after third address byte
// R17 - region clear into protected sector is not executed
// R18 - whole clear and deep sleep are one byte; select rises after bit eight
// R19 - whole clear only when both protect level bits are zero
// R20 - deep sleep takes effect after an entry delay
// R21 - in deep sleep only wake command accepted; starts in standby
// R22 - deep sleep rejected while a cycle runs
// R23 - bytes msb first; each select low starts fresh decode
`define SFCE_OP_QREAD      8'h0b
`define SFCE_OP_PROG       8'h02
`define SFCE_OP_RCLR       8'hd8
`define SFCE_OP_WCLR       8'hc7
`define SFCE_OP_SLEEP      8'hb9
`define SFCE_OP_WAKE       8'hab
`define SFCE_OP_WRITE_ENABLE_CMD       8'h06
`define SFCE_ERASED        8'hff
`define SFCE_PAGE_BYTES    256
`define SFCE_PROG_US       1400
`define SFCE_RCLR_US       800000
`define SFCE_WCLR_US       2500000
`define SFCE_SLEEP_US      3
`define SFCE_CLK_MHZ       10
`define SFCE_CYC(us)       ((us) * `SFCE_CLK_MHZ)
`endif

// ---- logic/sfce_sync.v ----
`timescale 1ns/1ns
module sfce_sync #(
  parameter W = 3
) (
  input  wire         ref_clk,
  input  wire         rst_n,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] meta_reg;
  // first stage read only by second stage
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b1}};
      sync_out <= {W{1'b1}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // sfce_sync

// ---- logic/sfce_engine.v ----
`timescale 1ns/1ns
`include "sfce_map.vh"
module sfce_engine #(
  parameter AW        = 17,
  parameter PROG_CYC  = `SFCE_CYC(`SFCE_PROG_US),
  parameter RCLR_CYC  = `SFCE_CYC(`SFCE_RCLR_US),
  parameter WCLR_CYC  = `SFCE_CYC(`SFCE_WCLR_US),
  parameter SLEEP_CYC = `SFCE_CYC(`SFCE_SLEEP_US)
) (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire cs_n,
  input  wire sclk,
  input  wire mosi,
  input  wire protect_level_hi,
  input  wire protect_level_lo,
  output reg  miso,
  output reg  miso_oe_n,
  output reg  write_busy_flag,
  output reg  write_enable_latch,
  output reg  deep_sleep
);
  localparam DEPTH = 1 << AW;
  localparam [AW-1:0] AMAX = {AW{1'b1}};
  localparam CW = 32;
  localparam [5:0] ST_IDLE = 6'h01, ST_PROG = 6'h02, ST_RCLR = 6'h04, ST_WCLR = 6'h08, ST_SLP = 6'h10,
                   ST_DONE = 6'h20;

  reg [7:0] mem [0:DEPTH-1];
  reg [7:0] pbuf [0:255];
  reg [255:0] pvalid_reg;

  wire [2:0] pins;
  sfce_sync #(.W(3)) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({cs_n, sclk, mosi}),
    .sync_out (pins)
  );
  wire cs_s = pins[2];
  wire sck_s = pins[1];
  wire din_s = pins[0];

  reg          sck_d_reg, cs_d_reg;
  reg  [7:0]   sh_reg, op_reg;
  reg  [2:0]   bit_reg;
  reg  [5:0]   byte_reg;
  reg  [AW-1:0] addr_reg, xaddr_reg;
  reg  [7:0]   pidx_reg;
  reg  [7:0]   out_reg;
  reg          rd_act_reg, rej_reg, asleep_reg;
  reg  [5:0]   st_reg;
  reg  [CW-1:0] cnt_reg;
  integer      i;

  wire rise = sck_s & ~sck_d_reg;
  wire fall = ~sck_s & sck_d_reg;
  wire cs_rise = cs_s & ~cs_d_reg;
  wire [7:0] sh_next = {sh_reg[6:0], din_s};     // R23
  wire byte_end = rise & (bit_reg == 3'd7);
  wire busy = (st_reg != ST_IDLE) && (st_reg != ST_SLP);

  // protect levels: 01 top quarter, 10 top half, 11 whole array
  function prot;
    input [AW-1:0] a;
    input [1:0] bp;
    begin
      case (bp)
        2'b01:   prot = (a[AW-1:AW-2] == 2'b11);
        2'b10:   prot = a[AW-1];
        2'b11:   prot = 1'b1;
        default: prot = 1'b0;
      endcase
    end
  endfunction

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // matches the synchroniser's reset level, so no false edge after reset
      sck_d_reg <= 1'b1;
      cs_d_reg <= 1'b1;
      sh_reg <= 8'h00;
      op_reg <= 8'h00;
      bit_reg <= 3'd0;
      byte_reg <= 6'd0;
      addr_reg <= {AW{1'b0}};
      xaddr_reg <= {AW{1'b0}};
      pidx_reg <= 8'h00;
      out_reg <= 8'h00;
      rd_act_reg <= 1'b0;
      rej_reg <= 1'b0;
      asleep_reg <= 1'b0;    // R21
      st_reg <= ST_IDLE;
      cnt_reg <= {CW{1'b0}};
      pvalid_reg <= 256'd0;
      miso <= 1'b0;
      miso_oe_n <= 1'b1;
      write_busy_flag <= 1'b0;
      write_enable_latch <= 1'b0;
      deep_sleep <= 1'b0;
    end else begin
      sck_d_reg <= sck_s;
      cs_d_reg <= cs_s;
      if (cs_s) begin
        // fresh decode on every select; driver off at once
        bit_reg <= 3'd0;   // R23
        byte_reg <= 6'd0;
        rd_act_reg <= 1'b0;
        miso_oe_n <= 1'b1; // R4
      end else begin
        if (rise) begin
          sh_reg <= sh_next;  // R2
          bit_reg <= bit_reg + 3'd1;
        end
        if (byte_end) begin
          if (byte_reg != 6'd63)
            byte_reg <= byte_reg + 6'd1;
          if (byte_reg == 6'd0) begin
            op_reg <= sh_next;
            rej_reg <= 1'b0;
            if (asleep_reg && sh_next != `SFCE_OP_WAKE)
              rej_reg <= 1'b1;  // R21
            if (busy)
              rej_reg <= 1'b1;  // R5 R22
            // a refused frame must not wipe the buffer of a running program
            if (sh_next == `SFCE_OP_PROG && !busy) begin  // R5
              pvalid_reg <= 256'd0;
            end
          end else if (byte_reg <= 6'd3) begin
            // refused frames keep the target of the running cycle
            if (!rej_reg)
              addr_reg <= {addr_reg[AW-9:0], sh_next};  // R22
          end else if (op_reg == `SFCE_OP_PROG && !rej_reg) begin
            // wraps in page; later bytes overwrite earlier ones
            pbuf[pidx_reg] <= sh_next;               // R8 R9
            pvalid_reg[pidx_reg] <= 1'b1;            // R10
            pidx_reg <= pidx_reg + 8'd1;              // R8
          end
          if (byte_reg == 6'd3 && !rej_reg) begin
            // low address byte is the one arriving now
            pidx_reg <= sh_next;  // R8
            xaddr_reg <= {addr_reg[AW-9:0], sh_next};
          end
          if (byte_reg == 6'd4 && op_reg == `SFCE_OP_QREAD && !rej_reg) begin
            out_reg <= mem[xaddr_reg];  // R1
            rd_act_reg <= 1'b1;
          end
        end
        if (fall && rd_act_reg) begin
          miso <= out_reg[7 - bit_reg];   // R2 R23
          miso_oe_n <= 1'b0;
          if (bit_reg == 3'd7) begin
            // next byte fetched during the last bit
            xaddr_reg <= (xaddr_reg == AMAX) ? {AW{1'b0}} : xaddr_reg + 1'b1;  // R3
            out_reg <= mem[(xaddr_reg == AMAX) ? {AW{1'b0}} : xaddr_reg + 1'b1];
          end
        end
      end

      if (cs_rise && !rej_reg && bit_reg == 3'd0) begin
        if (byte_reg == 6'd1 && op_reg == `SFCE_OP_WRITE_ENABLE_CMD)
          write_enable_latch <= 1'b1;
        if (byte_reg == 6'd1 && op_reg == `SFCE_OP_WAKE)
          asleep_reg <= 1'b0;
        if (byte_reg == 6'd1 && op_reg == `SFCE_OP_SLEEP) begin
          st_reg <= ST_SLP;     // R18
          cnt_reg <= SLEEP_CYC;  // R20
        end
        if (write_enable_latch) begin   // R6
          if (op_reg == `SFCE_OP_PROG && byte_reg >= 6'd5 && !prot(addr_reg, {protect_level_hi, protect_level_lo})) begin
            st_reg <= ST_PROG;  // R7 R11 R14 R13
            cnt_reg <= PROG_CYC;
            write_busy_flag <= 1'b1;
          end
          if (op_reg == `SFCE_OP_RCLR && byte_reg == 6'd4 && !prot(addr_reg, {protect_level_hi, protect_level_lo})) begin
            st_reg <= ST_RCLR;  // R16 R17 R13
            cnt_reg <= RCLR_CYC;
            write_busy_flag <= 1'b1;
          end
          if (op_reg == `SFCE_OP_WCLR && byte_reg == 6'd1 && !protect_level_hi && !protect_level_lo) begin
            st_reg <= ST_WCLR;  // R18 R19 R13
            cnt_reg <= WCLR_CYC;
            write_busy_flag <= 1'b1;
          end
        end
      end else begin
        case (st_reg)
          ST_IDLE: cnt_reg <= cnt_reg;
          ST_PROG, ST_RCLR, ST_WCLR: begin
            if (cnt_reg > 1) begin
              cnt_reg <= cnt_reg - 1'b1;
            end else begin
              write_enable_latch <= 1'b0;  // R13
              st_reg <= ST_DONE;
              if (st_reg == ST_PROG) begin
                for (i = 0; i < 256; i = i + 1)
                  if (pvalid_reg[i])
                    mem[{addr_reg[AW-1:8], i[7:0]}] <= mem[{addr_reg[AW-1:8], i[7:0]}] & pbuf[i];  // R12
              end else if (st_reg == ST_RCLR) begin
                for (i = 0; i < DEPTH; i = i + 1)
                  if (i[AW-1:AW-2] == addr_reg[AW-1:AW-2])
                    mem[i] <= `SFCE_ERASED;  // R15
              end else begin
                for (i = 0; i < DEPTH; i = i + 1)
                  mem[i] <= `SFCE_ERASED;
              end
            end
          end
          ST_DONE: begin
            write_busy_flag <= 1'b0;  // R13
            st_reg <= ST_IDLE;
          end
          ST_SLP: begin
            if (cnt_reg > 1) begin
              cnt_reg <= cnt_reg - 1'b1;
            end else begin
              asleep_reg <= 1'b1;
              st_reg <= ST_IDLE;
            end
          end
          default: st_reg <= ST_IDLE;
        endcase
      end
      deep_sleep <= asleep_reg;
    end
  end
endmodule // sfce_engine

// ---- verif/sfce_checker.sv ----
`timescale 1ns/1ns
module sfce_checker (
  input logic ref_clk,
  input logic rst_n,
  input logic cs_n,
  input logic sclk,
  input logic miso,
  input logic miso_oe_n,
  input logic write_busy_flag,
  input logic write_enable_latch,
  input logic deep_sleep
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  oe_release_a: assert property (cs_n [*4] |-> miso_oe_n)
    else $error("miso driven while deselected");
  oe_frame_a: assert property ($fell(miso_oe_n) |-> !cs_n)
    else $error("miso driver enabled outside a frame");
  shift_edge_a: assert property ($changed(miso) |-> !sclk)
    else $error("miso moved while sclk high");
  busy_quiet_a: assert property (write_busy_flag |-> miso_oe_n)
    else $error("read answered during busy cycle");
  busy_start_a: assert property ($rose(write_busy_flag) |-> cs_n && $past(write_enable_latch))
    else $error("cycle began without latch or in frame");
  busy_hold_a: assert property ($rose(write_busy_flag) |=> write_busy_flag [*8])
    else $error("busy cycle cut short");
  latch_end_a: assert property ($fell(write_busy_flag) |-> !write_enable_latch)
    else $error("latch still set after cycle");
  sleep_delay_a: assert property ($rose(deep_sleep) |-> !write_busy_flag && $past(cs_n, 5))
    else $error("sleep entered early or while busy");
  sleep_mute_a: assert property (deep_sleep |-> miso_oe_n && !write_busy_flag)
    else $error("activity while asleep");
  busy_cov: cover property ($rose(write_busy_flag));
  sleep_cov: cover property ($rose(deep_sleep));
  read_cov: cover property ($fell(miso_oe_n));
endmodule // sfce_checker

// ---- verif/sfce_host.sv ----
`timescale 1ns/1ns
module sfce_host (
  input  logic ref_clk,
  input  logic miso,
  output logic cs_n,
  output logic sclk,
  output logic mosi
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // 4 ref_clk per half period, slow enough for the two-stage sampler and its edge detect
  task automatic half();
    repeat (4) @(posedge ref_clk);
    #5;
  endtask
  task automatic sel(input logic v);
    half();
    cs_n = v;
    half();
  endtask
  task automatic xb(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      mosi = d[i];
      half();
      sclk = 1'b1;
      q[i] = miso;
      half();
      sclk = 1'b0;
    end
  endtask
endmodule // sfce_host

// ---- verif/serial_flash_cmd_engine_test.sv ----
`timescale 1ns/1ns
`include "sfce_map.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module serial_flash_cmd_engine_test;
  logic ref_clk, rst_n, protect_level_hi, protect_level_lo;
  logic cs_n, sclk, mosi, miso, miso_oe_n, write_busy_flag, write_enable_latch, deep_sleep;
  logic [7:0] q;
  logic [7:0] rx[$];
  logic [7:0] pb[$];
  int errors = 0, comparisons = 0, cyc = 0;
  always #50 ref_clk = ~ref_clk;
  sfce_engine #(
    .PROG_CYC  (600),
    .RCLR_CYC  (20),
    .WCLR_CYC  (20),
    .SLEEP_CYC (5)
  ) u_sfce_engine (
    .ref_clk            (ref_clk),
    .rst_n              (rst_n),
    .cs_n               (cs_n),
    .sclk               (sclk),
    .mosi               (mosi),
    .protect_level_hi   (protect_level_hi),
    .protect_level_lo   (protect_level_lo),
    .miso               (miso),
    .miso_oe_n          (miso_oe_n),
    .write_busy_flag    (write_busy_flag),
    .write_enable_latch (write_enable_latch),
    .deep_sleep         (deep_sleep)
  );
  sfce_host u_sfce_host (
    .ref_clk (ref_clk),
    .miso    (miso),
    .cs_n    (cs_n),
    .sclk    (sclk),
    .mosi    (mosi)
  );
  task automatic conclude();
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      conclude();
    end
  end
  task automatic send(input logic [7:0] b[$]);
    rx = {};
    u_sfce_host.sel(1'b0);
    foreach (b[i]) begin
      u_sfce_host.xb(b[i], q);
      rx.push_back(q);
    end
    u_sfce_host.sel(1'b1);
  endtask
  // look off the edge so registered outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask
  task automatic idle();
    for (int k = 0; k < 2000 && write_busy_flag !== 1'b0; k++) @(posedge ref_clk);
    wt(2);
  endtask
  // eb: whether the command is expected to start a cycle
  task automatic wcmd(input logic [7:0] b[$], input logic eb);
    send('{`SFCE_OP_WRITE_ENABLE_CMD});
    `CHK("latch_set", 1'b1, write_enable_latch)
    send(b);
    wt(2);
    `CHK("busy", eb, write_busy_flag)
    idle();
    `CHK("latch_after", ~eb, write_enable_latch)
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] e0, input logic [7:0] e1);
    send('{`SFCE_OP_QREAD, a[23:16], a[15:8], a[7:0], 8'h00, 8'h00, 8'h00});
    `CHK("rd0", e0, rx[5])
    `CHK("rd1", e1, rx[6])
  endtask
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    protect_level_hi = 1'b0;
    protect_level_lo = 1'b0;
    repeat (8) @(posedge ref_clk);
    #5 rst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    wcmd('{`SFCE_OP_WCLR}, 1'b1);
    wcmd('{`SFCE_OP_PROG, 8'h00, 8'h00, 8'hfe, 8'ha5, 8'h3c, 8'hf0}, 1'b1);
    rd(24'h0000fe, 8'ha5, 8'h3c);
    rd(24'h01ffff, `SFCE_ERASED, 8'hf0);
    wcmd('{`SFCE_OP_PROG, 8'h00, 8'h00, 8'h00, 8'h0f}, 1'b1);
    rd(24'h000000, 8'h00, `SFCE_ERASED);
    wcmd('{`SFCE_OP_RCLR, 8'h00, 8'h00, 8'h10}, 1'b1);
    rd(24'h0000fe, `SFCE_ERASED, `SFCE_ERASED);
    // 258 bytes into one page: the last two land on offsets 0 and 1
    pb = '{`SFCE_OP_PROG, 8'h00, 8'h01, 8'h00};
    for (int k = 0; k < 258; k++) pb.push_back(8'(k >> 1));
    wcmd(pb, 1'b1);
    rd(24'h000100, 8'h80, 8'h80);
    send('{`SFCE_OP_PROG, 8'h00, 8'h00, 8'h00, 8'h00});
    wt(2);
    `CHK("busy_nolatch", 1'b0, write_busy_flag)
    {protect_level_hi, protect_level_lo} = 2'b11;
    wcmd('{`SFCE_OP_PROG, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0);
    {protect_level_hi, protect_level_lo} = 2'b01;
    wcmd('{`SFCE_OP_WCLR}, 1'b0);
    wcmd('{`SFCE_OP_RCLR, 8'h01, 8'h80, 8'h00}, 1'b0);
    {protect_level_hi, protect_level_lo} = 2'b00;
    wcmd('{`SFCE_OP_RCLR, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0);
    wcmd('{`SFCE_OP_WCLR, 8'h00}, 1'b0);
    send('{`SFCE_OP_PROG, 8'h00, 8'h00, 8'h00, 8'h55});
    send('{`SFCE_OP_QREAD, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    send('{`SFCE_OP_SLEEP});
    wt(10);
    `CHK("sleep_busy", 1'b0, deep_sleep)
    `CHK("busy_kept", 1'b1, write_busy_flag)
    idle();
    rd(24'h000000, 8'h55, `SFCE_ERASED);
    // latch armed before sleeping, so only the sleep state can refuse the clear
    send('{`SFCE_OP_WRITE_ENABLE_CMD});
    send('{`SFCE_OP_SLEEP});
    wt(10);
    `CHK("asleep", 1'b1, deep_sleep)
    send('{`SFCE_OP_WCLR});
    wt(2);
    `CHK("busy_asleep", 1'b0, write_busy_flag)
    send('{`SFCE_OP_WAKE});
    wt(6);
    `CHK("awake", 1'b0, deep_sleep)
    conclude();
  end
endmodule // serial_flash_cmd_engine_test
bind sfce_engine sfce_checker u_sfce_checker (.ref_clk, .rst_n, .cs_n, .sclk, .miso, .miso_oe_n,
  .write_busy_flag, .write_enable_latch, .deep_sleep);
